//--- hw/pcxb_pkg.sv
package pcxb_pkg;

  // ==========================================================================
  // Pin map: ports 0-2 reach the crossbar, ports 3-5 are plain I/O,
  // and port 6 is open-drain only.
  // ==========================================================================
  localparam int PIN_COUNT  = 45;
  localparam int XBAR_PINS  = 24;
  localparam int BANK_COUNT = 6;
  localparam int P6_FIRST   = 43;
  localparam int DEBUG_PIN  = 42;
  // Pin to read-back delay: two synchroniser flops and the read register.
  localparam int READ_LATENCY = 3;

  // ==========================================================================
  // Crossbar resources in priority order, highest first.
  // ==========================================================================
  localparam int RES_COUNT  = 7;
  localparam int RES_TX     = 0;
  localparam int RES_RX     = 1;
  localparam int RES_SDA    = 2;
  localparam int RES_SCL    = 3;
  localparam int RES_SYSCLK = 4;
  localparam int RES_T0     = 5;
  localparam int RES_T1     = 6;

  // ==========================================================================
  // Field positions in the three crossbar configuration registers.
  // ==========================================================================
  localparam int CFG0_UART_SEL   = 0;
  localparam int CFG0_SMBUS_SEL  = 1;
  localparam int CFG1_SYSCLK_SEL = 0;
  localparam int CFG1_T0_SEL     = 1;
  localparam int CFG1_T1_SEL     = 2;
  localparam int CFG1_WEAK_PUD   = 7;
  localparam int CFG2_XBAR_EN    = 6;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [PIN_COUNT-1:0] IN_MODE_RST  = '1;
  localparam logic [PIN_COUNT-1:0] OUT_MODE_RST = '0;
  localparam logic [XBAR_PINS-1:0] SKIP_RST     = '0;
  localparam logic [7:0]           CFG_RST      = 8'h00;
  localparam logic [XBAR_PINS-1:0] LSB_ONE      = 24'h00_0001;

  // Crossbar configuration registers travel together.
  typedef struct packed {
    logic [7:0] cfg2;
    logic [7:0] cfg1;
    logic [7:0] cfg0;
  } pcxb_xbar_cfg_t;

  // Peripheral side of each crossbar resource.
  typedef struct packed {
    logic [RES_COUNT-1:0] value;
    logic [RES_COUNT-1:0] drive;
  } pcxb_periph_t;

endpackage : pcxb_pkg

//--- hw/pcxb_port_io.sv
`timescale 1ns/1ns
// Overview of operation
// - Ports 0-2 crossbar or analog; 3-6 GPIO or analog.
// - Port latch read shows pin state on digital pins; analog pins read low.
// - Per-pin push-pull or open-drain output select.
// - Two drive strengths per bank, ports 0-5.
// - Port 6 is open-drain only, never push-pull.
// - Port 5 pin 2 shares debug data line.
// - Input mode bit: 1 digital, 0 analog.
// - Analog pins: no pullup, driver, or receiver.
// - Input mode resets to digital on every pin.
// - Pullup-disable clear enables pullups on open-drain pins.
// - Pullup-disable bit ignores push-pull pins.
// - Pullup off while pin drives low.
// - Crossbar enable bit activates selected peripheral routing.
// - Crossbar off: pins are plain inputs, except the debug pin while debug is active.
// - Output drivers only on while crossbar enabled, or on the debug pin while debug is active.
// - Each resource takes lowest unassigned pin, in priority.
// - Skipped pins count as already assigned.
// - Two-wire bus and serial port take pin pairs.
module pcxb_port_io #(
  parameter int PINS = pcxb_pkg::PIN_COUNT,
  parameter int XP   = pcxb_pkg::XBAR_PINS,
  parameter int RES  = pcxb_pkg::RES_COUNT
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Configuration written by software.
  input  wire logic [PINS-1:0]         port_input_mode_reg,
  input  wire logic [PINS-1:0]         port_output_mode_reg,
  input  wire logic [XP-1:0]           port_skip_reg,
  input  wire pcxb_pkg::pcxb_xbar_cfg_t xbar_cfg,
  input  wire logic [pcxb_pkg::BANK_COUNT-1:0] bank_drive_sel,
  // Port latch and read-back.
  input  wire logic [PINS-1:0]         port_latch,
  output logic [PINS-1:0]              port_read,
  // Crossbar peripherals.
  input  wire pcxb_pkg::pcxb_periph_t  periph,
  output logic [RES-1:0]               periph_in,
  // Debug data line.
  input  wire logic                    debug_active,
  input  wire logic                    debug_data_out,
  input  wire logic                    debug_data_drive,
  output logic                         debug_data_signal,
  // Pin cells.
  input  wire logic [PINS-1:0]         pin_in,
  output logic [PINS-1:0]              pin_out,
  output logic [PINS-1:0]              pin_oe_n,
  output logic [PINS-1:0]              pin_pullup_en,
  output logic [PINS-1:0]              pin_rx_en,
  output logic [pcxb_pkg::BANK_COUNT-1:0] bank_high_drive
);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [PINS-1:0]          in_mode;
  logic [PINS-1:0]          out_mode;
  logic [XP-1:0]            skip;
  pcxb_pkg::pcxb_xbar_cfg_t xcfg;
  logic [PINS-1:0]          sync1;
  logic [PINS-1:0]          sync2;

  // Software settings are held here so reset values are defined locally.
  always_ff @(posedge clk) begin
    if (rst) begin
      in_mode  <= pcxb_pkg::IN_MODE_RST;
      out_mode <= pcxb_pkg::OUT_MODE_RST;
      skip     <= pcxb_pkg::SKIP_RST;
      xcfg     <= {pcxb_pkg::CFG_RST, pcxb_pkg::CFG_RST, pcxb_pkg::CFG_RST};
    end else begin
      in_mode  <= port_input_mode_reg;
      out_mode <= port_output_mode_reg;
      skip     <= port_skip_reg;
      xcfg     <= xbar_cfg;
    end
  end

  // Pins are asynchronous to clk, so they pass two flops first.
  always_ff @(posedge clk) begin
    sync1 <= pin_in;
    sync2 <= sync1;
  end

  // ==========================================================================
  // Crossbar allocation
  // ==========================================================================
  // Isolates the lowest free pin; reused by every resource stage.
  function automatic logic [XP-1:0] pick_lowest(input logic [XP-1:0] free);
    pick_lowest = free & (~free + pcxb_pkg::LSB_ONE);
  endfunction : pick_lowest

  logic                     xbar_en;
  logic                     weak_pud;
  logic [RES-1:0]           res_en;
  logic [RES:0][XP-1:0]     taken;
  logic [RES-1:0][XP-1:0]   sel;

  // Pair selects enable both pins of their peripheral at once.
  assign xbar_en  = xcfg.cfg2[pcxb_pkg::CFG2_XBAR_EN];
  assign weak_pud = xcfg.cfg1[pcxb_pkg::CFG1_WEAK_PUD];
  assign res_en[pcxb_pkg::RES_TX]     = xcfg.cfg0[pcxb_pkg::CFG0_UART_SEL];
  assign res_en[pcxb_pkg::RES_RX]     = xcfg.cfg0[pcxb_pkg::CFG0_UART_SEL];
  assign res_en[pcxb_pkg::RES_SDA]    = xcfg.cfg0[pcxb_pkg::CFG0_SMBUS_SEL];
  assign res_en[pcxb_pkg::RES_SCL]    = xcfg.cfg0[pcxb_pkg::CFG0_SMBUS_SEL];
  assign res_en[pcxb_pkg::RES_SYSCLK] = xcfg.cfg1[pcxb_pkg::CFG1_SYSCLK_SEL];
  assign res_en[pcxb_pkg::RES_T0]     = xcfg.cfg1[pcxb_pkg::CFG1_T0_SEL];
  assign res_en[pcxb_pkg::RES_T1]     = xcfg.cfg1[pcxb_pkg::CFG1_T1_SEL];

  // Skipped pins seed the taken mask, so they look already assigned.
  assign taken[0] = skip;

  // Each stage grabs the lowest pin left by the stages above it.
  // A resource with no pin left simply gets none.
  genvar k;
  generate
    for (k = 0; k < RES; k++) begin : g_alloc
      assign sel[k]     = res_en[k] ? pick_lowest(~taken[k]) : '0;
      assign taken[k+1] = taken[k] | sel[k];
    end
  endgenerate

  // ==========================================================================
  // Per-pin drive decision
  // ==========================================================================
  logic [PINS-1:0] val;
  logic [PINS-1:0] req;
  logic [PINS-1:0] push_pull;
  logic [PINS-1:0] dig;
  logic [PINS-1:0] gate;
  logic [PINS-1:0] next_oe_n;
  logic [PINS-1:0] next_pullup;
  logic [RES-1:0]  next_periph_in;

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      logic [RES-1:0] col;
      logic           own;
      logic           dbg;
      if (i < XP) begin : g_xbar
        for (k = 0; k < RES; k++) begin : g_col
          assign col[k] = xbar_en & sel[k][i];
        end
      end else begin : g_gpio
        assign col = '0;
      end
      assign own = |col;
      assign dbg = (i == pcxb_pkg::DEBUG_PIN) && debug_active;
      // An active debug pin follows the debug data, peripheral-owned pins the peripheral, others the latch.
      assign val[i] = dbg ? debug_data_out :
                      own ? |(col & periph.value) : port_latch[i];
      assign req[i] = dbg ? debug_data_drive :
                      own ? |(col & periph.drive) : 1'b1;
      // Port 6 never drives high; its mode bit is ignored.
      assign push_pull[i] = (i >= pcxb_pkg::P6_FIRST) ? 1'b0 :
                            (dbg | out_mode[i]);
      assign dig[i]  = in_mode[i];
      // The debug line works even with the crossbar off.
      assign gate[i] = dig[i] & (xbar_en | dbg);
    end
  endgenerate

  // Open-drain only pulls low; a driven low turns the pullup off.
  assign next_oe_n   = ~(gate & req & (push_pull | ~val));
  assign next_pullup = dig & ~push_pull & {PINS{~weak_pud}} &
                       ~(~next_oe_n & ~val);

  // Inputs to peripherals come from whichever pin each one owns.
  generate
    for (k = 0; k < RES; k++) begin : g_pin_in
      assign next_periph_in[k] = |(sel[k] & sync2[XP-1:0] & in_mode[XP-1:0]);
    end
  endgenerate

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Pad controls are registered so the pads never see decode glitches.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out         <= '0;
      pin_oe_n        <= '1;
      pin_pullup_en   <= '0;
      pin_rx_en       <= '0;
      bank_high_drive <= '0;
    end else begin
      pin_out         <= val;
      pin_oe_n        <= next_oe_n;
      pin_pullup_en   <= next_pullup;
      pin_rx_en       <= dig;
      bank_high_drive <= bank_drive_sel;
    end
  end

  // Read-back ignores the crossbar; analog pins read low.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_read         <= '0;
      periph_in         <= '0;
      debug_data_signal <= 1'b0;
    end else begin
      port_read         <= sync2 & in_mode;
      periph_in         <= xbar_en ? next_periph_in : '0;
      debug_data_signal <= sync2[pcxb_pkg::DEBUG_PIN];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic [PINS-1:0] p6_mask;
  assign p6_mask = {PINS{1'b1}} << pcxb_pkg::P6_FIRST;

  // Union of every stage's grant, so the skip check covers each resource.
  logic [XP-1:0] sel_union;
  always_comb begin
    sel_union = '0;
    for (int n = 0; n < RES; n++) begin
      sel_union = sel_union | sel[n];
    end
  end

  sequence s_reset_release;
    rst ##1 !rst;
  endsequence

  property p_reset_state;
    @(posedge clk) s_reset_release |-> (in_mode == '1) && !xbar_en && (&pin_oe_n);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Reset did not leave digital inputs with crossbar off.");

  property p_analog_off;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> ((~$past(in_mode) & (~pin_oe_n | pin_pullup_en | pin_rx_en)) == '0);
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("Analog pin has driver, pullup or receiver on.");

  property p_xbar_off;
    @(posedge clk) disable iff (rst)
      (!xbar_en && !debug_active) |=> (&pin_oe_n);
  endproperty
  a_xbar_off: assert property (p_xbar_off)
    else $error("Pin driven while crossbar disabled.");

  property p_p6_open_drain;
    @(posedge clk) disable iff (rst)
      ((~pin_oe_n & pin_out & p6_mask) == '0);
  endproperty
  a_p6_open_drain: assert property (p_p6_open_drain)
    else $error("Port 6 pin drove a high level.");

  property p_pullup_low;
    @(posedge clk) disable iff (rst)
      ((pin_pullup_en & ~pin_oe_n & ~pin_out) == '0);
  endproperty
  a_pullup_low: assert property (p_pullup_low)
    else $error("Pullup on while pin drives low.");

  property p_pp_no_pullup;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> (($past(out_mode) & ~p6_mask & pin_pullup_en) == '0);
  endproperty
  a_pp_no_pullup: assert property (p_pp_no_pullup)
    else $error("Push-pull pin has its pullup on.");

  sequence s_pud_held;
    weak_pud ##1 weak_pud;
  endsequence

  property p_weak_pud;
    @(posedge clk) disable iff (rst)
      s_pud_held |-> (pin_pullup_en == '0);
  endproperty
  a_weak_pud: assert property (p_weak_pud)
    else $error("Pullup on while pullup disable is set.");

  property p_read_back;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> port_read == ($past(pin_in, pcxb_pkg::READ_LATENCY) & $past(in_mode));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("Port read does not match pin three cycles back.");

  property p_skip_honoured;
    @(posedge clk) disable iff (rst)
      ((sel_union & skip) == '0);
  endproperty
  a_skip_honoured: assert property (p_skip_honoured)
    else $error("Crossbar assigned a skipped pin.");

  property p_first_lowest;
    @(posedge clk) disable iff (rst)
      res_en[pcxb_pkg::RES_TX] |-> sel[pcxb_pkg::RES_TX] == pick_lowest(~skip);
  endproperty
  a_first_lowest: assert property (p_first_lowest)
    else $error("Top resource did not take lowest free pin.");

endmodule : pcxb_port_io

//--- verification/pcxb_board.sv
`timescale 1ns/1ns
// ============================================================
// Board circuitry on the port pins.
// ============================================================
module pcxb_board (
  // Device pin cells.
  input  wire logic [pcxb_pkg::PIN_COUNT-1:0] pin_out,
  input  wire logic [pcxb_pkg::PIN_COUNT-1:0] pin_oe_n,
  input  wire logic [pcxb_pkg::PIN_COUNT-1:0] pin_pullup_en,
  // External drivers on the board.
  input  wire logic [pcxb_pkg::PIN_COUNT-1:0] ext_val,
  input  wire logic [pcxb_pkg::PIN_COUNT-1:0] ext_en,
  // Resolved pin levels.
  output logic [pcxb_pkg::PIN_COUNT-1:0]      pin_level
);
  // The device wins, then the board driver, then the weak pullup.
  // A floating pin with no pullup shows the opposite of the device's value,
  // so a stale level can never pass for a correct one.
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                   | (pin_oe_n & ~ext_en & (pin_pullup_en | ~pin_out));
endmodule : pcxb_board

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int N = pcxb_pkg::PIN_COUNT;
  localparam logic [N-1:0] P6 = 45'h1800_0000_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [N-1:0] in_mode, out_mode, latch, ext_val, ext_en, level;
  logic [N-1:0] p_read, p_out, p_oe_n, p_pu, p_rx;
  logic [23:0] skip;
  logic [5:0] bank, hd;
  logic [6:0] p_in;
  logic dbg_act, dbg_out, dbg_drv, dbg_sig;
  pcxb_pkg::pcxb_xbar_cfg_t cfg;
  pcxb_pkg::pcxb_periph_t periph;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] lfsr = 32'h16ea_2215;

  // ============================================================
  // Clock, device and board.
  // ============================================================
  always #25 clk = ~clk;

  pcxb_port_io uut (.clk(clk), .rst(rst), .port_input_mode_reg(in_mode),
    .port_output_mode_reg(out_mode), .port_skip_reg(skip), .xbar_cfg(cfg),
    .bank_drive_sel(bank), .port_latch(latch), .port_read(p_read), .periph(periph),
    .periph_in(p_in), .debug_active(dbg_act), .debug_data_out(dbg_out),
    .debug_data_drive(dbg_drv), .debug_data_signal(dbg_sig), .pin_in(level),
    .pin_out(p_out), .pin_oe_n(p_oe_n), .pin_pullup_en(p_pu), .pin_rx_en(p_rx),
    .bank_high_drive(hd));

  pcxb_board board (.pin_out(p_out), .pin_oe_n(p_oe_n),
    .pin_pullup_en(p_pu), .ext_val(ext_val), .ext_en(ext_en), .pin_level(level));

  // ============================================================
  // Helpers.
  // ============================================================
  // Random words come from a shift register so that every run repeats.
  function automatic logic [N-1:0] rnd();
    logic [N-1:0] v;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v[31:0] = lfsr;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v[N-1:32] = lfsr[N-33:0];
    return v;
  endfunction : rnd

  // Pullup on for digital open-drain pins unless disabled or driving low.
  function automatic logic [N-1:0] pull(logic [N-1:0] im, om, dv, lt, logic pud);
    return im & ~(om & ~P6) & {N{~pud}} & ~(dv & ~lt);
  endfunction : pull

  // A pin drives when digital, gated on, and push-pull or pulling low.
  function automatic logic [N-1:0] drv(logic [N-1:0] im, om, lt, logic en);
    return im & {N{en}} & ((om & ~P6) | ~lt);
  endfunction : drv

  // The config path and the read path both settle within this wait.
  task automatic settle;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic chk(input string nm, input logic [N-1:0] e, input logic [N-1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test;
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // A hung run is cut short and judged as failed.
  initial begin
    #1_000_000;
    mismatches++;
    stop_test();
  end

  // ============================================================
  // Main sequence.
  // ============================================================
  initial begin
    logic [N-1:0] r, d, pu, lv;
    pcxb_pkg::pcxb_xbar_cfg_t c;
    in_mode = '1; out_mode = '0; latch = '0; ext_val = '0; ext_en = '1;
    skip = '0; cfg = '0; bank = '0; periph = '0;
    dbg_act = 1'b0; dbg_out = 1'b0; dbg_drv = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("oe_n", '1, p_oe_n);
    chk("rx_en", '1, p_rx);
    // Random configs with no peripheral selected, every fourth all open-drain.
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      r = rnd();
      in_mode <= (i % 4 == 0) ? '1 : r;
      r = rnd();
      out_mode <= (i % 4 == 0) ? '0 : r;
      r = rnd();
      latch <= r;
      r = rnd();
      ext_en <= r;
      r = rnd();
      ext_val <= r;
      bank <= r[5:0];
      c = '0;
      c.cfg2[pcxb_pkg::CFG2_XBAR_EN] = r[6];
      c.cfg1[pcxb_pkg::CFG1_WEAK_PUD] = r[7];
      cfg <= c;
      settle();
      d = drv(in_mode, out_mode, latch, c.cfg2[pcxb_pkg::CFG2_XBAR_EN]);
      pu = pull(in_mode, out_mode, d, latch, c.cfg1[pcxb_pkg::CFG1_WEAK_PUD]);
      lv = (d & latch) | (~d & ext_en & ext_val) | (~d & ~ext_en & (pu | ~latch));
      chk("oe_n", ~d, p_oe_n);
      chk("pin_out", latch & d, p_out & d);
      chk("pullup", pu, p_pu);
      chk("rx_en", in_mode, p_rx);
      chk("port_read", in_mode & lv, p_read);
      chk("periph_in", '0, p_in);
      chk("bank", bank, hd);
    end
    // Modes, skips and selections together, enable one cycle later; pins 0 and 1 skipped.
    @(posedge clk);
    in_mode <= '1; out_mode <= '1; latch <= '1;
    skip <= 24'h00_0003;
    ext_en <= '1;
    ext_val <= 45'h0000_0000_0108;
    periph <= {7'b000_0100, 7'b001_0101};
    c = '0;
    c.cfg0[pcxb_pkg::CFG0_UART_SEL] = 1'b1;
    c.cfg0[pcxb_pkg::CFG0_SMBUS_SEL] = 1'b1;
    c.cfg1[pcxb_pkg::CFG1_SYSCLK_SEL] = 1'b1;
    c.cfg1[pcxb_pkg::CFG1_T0_SEL] = 1'b1;
    c.cfg1[pcxb_pkg::CFG1_T1_SEL] = 1'b1;
    cfg <= c;
    @(posedge clk);
    c.cfg2[pcxb_pkg::CFG2_XBAR_EN] = 1'b1;
    cfg <= c;
    settle();
    chk("alloc oe_n", 9'h1a8, p_oe_n[8:0]);
    chk("alloc out", 3'b010, {p_out[6], p_out[4], p_out[2]});
    chk("alloc in", 7'h46, p_in);
    // Debug owns its pin even with the crossbar off.
    @(posedge clk);
    cfg <= '0;
    dbg_act <= 1'b1; dbg_drv <= 1'b1; dbg_out <= 1'b1;
    settle();
    chk("debug pin", 2'b01, {p_oe_n[42], p_out[42]});
    chk("debug in", 1'b1, dbg_sig);
    @(posedge clk);
    dbg_drv <= 1'b0; ext_val <= '0;
    settle();
    chk("debug rel", 2'b10, {p_oe_n[42], dbg_sig});
    // A reset in mid-run with the crossbar on switches every driver off.
    @(posedge clk);
    dbg_act <= 1'b0;
    cfg <= c;
    settle();
    chk("relock oe_n", 9'h1a8, p_oe_n[8:0]);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("reset oe_n", '1, p_oe_n);
    @(posedge clk);
    rst <= 1'b0;
    // One edge after release every driver is still off.
    @(posedge clk);
    @(negedge clk);
    chk("release oe_n", '1, p_oe_n);
    settle();
    chk("restart oe_n", 9'h1a8, p_oe_n[8:0]);
    stop_test();
  end
endmodule : testbench
